// [core/option_cfg_pkg.sv]
// Constants, field layout, bus map and state types for the option bytes.
//Contract
//- The option word has no bus address and is reached only in prog mode.
//- The option word may be written once; later writes are refused.
//- An unprogrammed part holds 00h in the option word.
//- A mask part has a fixed word and refuses any read of it.
//- Bit 9 low forbids stop with watchdog; high allows it if NMI is high.
//- Bit 8 switches the low-voltage detector off or on.
//- Bit 7 high blocks external readout of program memory.
//- Bit 6 picks crystal-type (0) or RC (1) main oscillator.
//- Bit 3 connects the NMI pin pull-up.
//- Bit 1 high keeps the watchdog on; low leaves it to software.
//- Bit 0 enables the oscillator safeguard.
package option_cfg_pkg;
  localparam int unsigned CFG_W          = 16;
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned BE_W           = 4;
  localparam logic [15:0] SHIPPED_VALUE  = 16'h0000;
  localparam logic [15:0] RESERVED_MASK  = 16'hfc34;
  localparam logic [15:0] RESERVED_ONES  = 16'h0414;
  localparam logic [15:0] MASK_DEFAULT   = 16'h0414;
  localparam int unsigned STOP_SWE_BIT   = 9;
  localparam int unsigned DETECT_BIT     = 8;
  localparam int unsigned READOUT_BIT    = 7;
  localparam int unsigned CLK_SEL_BIT    = 6;
  localparam int unsigned PULLUP_BIT     = 3;
  localparam int unsigned HW_WDOG_BIT    = 1;
  localparam int unsigned SAFEGUARD_BIT  = 0;
  localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET  = 4'h4;
  localparam int unsigned CTRL_WDOG_BIT  = 0;
  localparam int unsigned CTRL_STOP_BIT  = 1;
  localparam int unsigned STAT_WDOG_BIT  = 0;
  localparam int unsigned STAT_STOP_BIT  = 1;
  localparam int unsigned STAT_VALID_BIT = 2;
  localparam int unsigned LANE0          = 0;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_RUN  = 2'h1,
    ST_PROG = 2'h3
  } phase_type;

  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] offset);
    return addr == offset;
  endfunction

  // Reserved positions carry no meaning, so they are forced to their
  // fixed pattern whatever the tool left in them.
  function automatic logic [15:0] clean_cfg(input logic [15:0] raw);
    return (raw & ~RESERVED_MASK) | RESERVED_ONES;
  endfunction
endpackage

// [core/otp_store.sv]
// One-time-programmable store for the option word with registered read.
`timescale 1ns/1ps
module otp_store
  import option_cfg_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             otp_blank,
  input  wire logic             we,
  input  wire logic [CFG_W-1:0] wdata,
  output logic      [CFG_W-1:0] rdata,
  output logic                  locked
);
  typedef struct packed {
    logic [CFG_W-1:0] cells;
    logic             locked;
    logic [CFG_W-1:0] rdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    cells: SHIPPED_VALUE, locked: 1'b0, rdata: SHIPPED_VALUE};

  state_type s_q;
  state_type s_d;

  // Fuse cells survive the system reset; only a blank die clears them.
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = s_q.cells;
    if (we && !s_q.locked)
    begin
      s_d.cells  = wdata;
      s_d.locked = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge otp_blank)
  begin
    if (otp_blank)
      s_q <= STATE_RESET;
    else
      s_q <= s_d;
  end

  assign rdata  = s_q.rdata;
  assign locked = s_q.locked;

  shipped_blank_a: assert property (
    @(posedge sys_clk) disable iff (otp_blank)
    !s_q.locked |-> ##1 rdata == SHIPPED_VALUE)
    else $error("blank store does not read as shipped value");

  write_once_a: assert property (
    @(posedge sys_clk) disable iff (otp_blank)
    s_q.locked |=> s_q.cells == $past(s_q.cells) && s_q.locked)
    else $error("locked option cells changed");
endmodule // otp_store

// [core/stop_gate.sv]
// Watchdog enable and stop-mode permission derived from the option word.
`timescale 1ns/1ps
module stop_gate
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hw_select,
  input  wire logic stop_swe,
  input  wire logic sw_enable,
  input  wire logic stop_req,
  input  wire logic nmi_level,
  output logic      watchdog_active,
  output logic      stop_grant
);
  typedef struct packed {
    logic wdog;
    logic grant;
  } state_type;

  localparam state_type STATE_RESET = '{wdog: 1'b0, grant: 1'b0};

  state_type s_q;
  state_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.wdog  = hw_select | sw_enable;
    s_d.grant = stop_req & (~s_d.wdog | (stop_swe & nmi_level));
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_q <= STATE_RESET;
    else
      s_q <= s_d;
  end

  assign watchdog_active = s_q.wdog;
  assign stop_grant      = s_q.grant;

  wdog_forced_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    hw_select |=> watchdog_active)
    else $error("hardware watchdog not active");

  stop_blocked_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    stop_grant |-> $past(stop_req) &&
      (!watchdog_active || ($past(stop_swe) && $past(nmi_level))))
    else $error("stop granted with watchdog running");

  stop_wdog_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    stop_grant && watchdog_active);
endmodule // stop_gate

// [core/option_byte_config.sv]
// Option word loader: programming port, reset latch and Avalon-MM control.
`timescale 1ns/1ps
module option_byte_config
  import option_cfg_pkg::*;
#(
  parameter logic             MASK_ROM    = 1'b0,
  parameter logic [CFG_W-1:0] MASK_CONFIG = MASK_DEFAULT
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              otp_blank,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [BE_W-1:0]   byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  input  wire logic              prog_mode,
  input  wire logic              prog_write,
  input  wire logic              prog_read,
  input  wire logic [CFG_W-1:0]  prog_wdata,
  output logic      [CFG_W-1:0]  prog_rdata,
  output logic                   prog_done,
  output logic                   prog_reject,
  input  wire logic              nmi_level,
  output logic                   watchdog_active,
  output logic                   stop_grant,
  output logic                   config_valid,
  output logic                   stop_with_watchdog_enable,
  output logic                   low_voltage_detect_enable,
  output logic                   readout_lock,
  output logic                   ext_readout_allow,
  output logic                   clock_source_select,
  output logic                   nonmaskable_pullup_enable,
  output logic                   hardware_watchdog_select,
  output logic                   safeguard_enable
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    phase_type         phase;
    logic [CFG_W-1:0]  cfg;
    logic              wdog_sw;
    logic              stop_req;
    logic              waitreq;
    logic [DATA_W-1:0] rdata;
    logic [CFG_W-1:0]  prog_rdata;
    logic              prog_done;
    logic              prog_reject;
    logic              readout_ok;
    logic              valid;
    logic              otp_we;
    logic [CFG_W-1:0]  otp_wdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    phase:       ST_LOAD,
    cfg:         SHIPPED_VALUE,
    wdog_sw:     1'b0,
    stop_req:    1'b0,
    waitreq:     1'b1,
    rdata:       '0,
    prog_rdata:  '0,
    prog_done:   1'b0,
    prog_reject: 1'b0,
    readout_ok:  1'b0,
    valid:       1'b0,
    otp_we:      1'b0,
    otp_wdata:   '0};

  state_type         s_q;
  state_type         s_d;
  logic [CFG_W-1:0]  otp_rdata;
  logic              otp_locked;
  logic [DATA_W-1:0] read_value;
  logic              running;

  ////////////////////////////////////////////////////////////////////////
  otp_store u_store
  (
    .sys_clk   (sys_clk),
    .otp_blank (otp_blank),
    .we        (s_q.otp_we),
    .wdata     (s_q.otp_wdata),
    .rdata     (otp_rdata),
    .locked    (otp_locked)
  );

  stop_gate u_gate
  (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .hw_select       (s_q.cfg[HW_WDOG_BIT]),
    .stop_swe        (s_q.cfg[STOP_SWE_BIT]),
    .sw_enable       (s_q.wdog_sw),
    .stop_req        (s_q.stop_req),
    .nmi_level       (nmi_level),
    .watchdog_active (watchdog_active),
    .stop_grant      (stop_grant)
  );

  assign running = s_q.phase != ST_LOAD;

  ////////////////////////////////////////////////////////////////////////
  // The bus view carries control and live status only; the option word
  // itself is never placed on it.
  always_comb
  begin
    read_value = '0;
    if (reg_hit(address, CTRL_OFFSET))
    begin
      read_value[CTRL_WDOG_BIT] = s_q.wdog_sw;
      read_value[CTRL_STOP_BIT] = s_q.stop_req;
    end
    else if (reg_hit(address, STATUS_OFFSET))
    begin
      read_value[STAT_WDOG_BIT]  = watchdog_active;
      read_value[STAT_STOP_BIT]  = stop_grant;
      read_value[STAT_VALID_BIT] = running;
    end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.prog_done   = 1'b0;
    s_d.prog_reject = 1'b0;
    s_d.otp_we      = 1'b0;
    s_d.readout_ok  = prog_mode & running &
                      ~s_q.cfg[READOUT_BIT];
    case (s_q.phase)
      ST_LOAD:
      begin
        // A newly programmed word only takes effect at the next reset.
        if (MASK_ROM)
          s_d.cfg = clean_cfg(MASK_CONFIG);
        else
          s_d.cfg = clean_cfg(otp_rdata);
        s_d.phase = ST_RUN;
        s_d.valid = 1'b1;
      end
      ST_RUN:
      begin
        if (prog_mode && prog_write)
        begin
          if (MASK_ROM || otp_locked)
            s_d.prog_reject = 1'b1;
          else
          begin
            s_d.otp_we    = 1'b1;
            s_d.otp_wdata = prog_wdata;
            s_d.phase     = ST_PROG;
          end
        end
        else if (prog_mode && prog_read)
        begin
          if (MASK_ROM)
            s_d.prog_reject = 1'b1;
          else
          begin
            s_d.prog_rdata = otp_rdata;
            s_d.prog_done  = 1'b1;
          end
        end
      end
      ST_PROG:
      begin
        s_d.prog_done = 1'b1;
        s_d.phase     = ST_RUN;
      end
      default:
      begin
        s_d.phase = ST_LOAD;
        s_d.valid = 1'b0;
      end
    endcase

    // Two-cycle slave: waitrequest drops for one cycle per access.
    if ((read || write) && s_q.waitreq)
    begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = read ? read_value : '0;
    end
    else if (!s_q.waitreq)
    begin
      s_d.waitreq = 1'b1;
      if (write && byteenable[LANE0] && reg_hit(address, CTRL_OFFSET))
      begin
        // Software may start the watchdog but never stop it.
        s_d.wdog_sw  = s_q.wdog_sw | writedata[CTRL_WDOG_BIT];
        s_d.stop_req = writedata[CTRL_STOP_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_q <= STATE_RESET;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  assign readdata                  = s_q.rdata;
  assign waitrequest               = s_q.waitreq;
  assign prog_rdata                = s_q.prog_rdata;
  assign prog_done                 = s_q.prog_done;
  assign prog_reject               = s_q.prog_reject;
  assign config_valid              = s_q.valid;
  assign stop_with_watchdog_enable = s_q.cfg[STOP_SWE_BIT];
  assign low_voltage_detect_enable = s_q.cfg[DETECT_BIT];
  assign readout_lock              = s_q.cfg[READOUT_BIT];
  assign ext_readout_allow         = s_q.readout_ok;
  assign clock_source_select       = s_q.cfg[CLK_SEL_BIT];
  assign nonmaskable_pullup_enable = s_q.cfg[PULLUP_BIT];
  assign hardware_watchdog_select  = s_q.cfg[HW_WDOG_BIT];
  assign safeguard_enable          = s_q.cfg[SAFEGUARD_BIT];

  ////////////////////////////////////////////////////////////////////////
  cfg_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    running && $past(running) |-> s_q.cfg == $past(s_q.cfg))
    else $error("option word changed during operation");

  // The release edge itself is skipped through the sampled reset, since
  // the load only happens one edge after rst has gone away.
  cfg_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(running) && !$past(rst) |-> running && config_valid &&
      s_q.cfg == clean_cfg(MASK_ROM ? MASK_CONFIG : $past(otp_rdata)))
    else $error("option word not latched after reset");

  prog_gated_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (s_q.phase == ST_RUN) && !prog_mode |=>
      !prog_done && !prog_reject && !s_q.otp_we)
    else $error("option access outside programming mode");

  bus_hidden_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !waitrequest && read && reg_hit(address, STATUS_OFFSET) |->
      readdata[CFG_W-1:STAT_VALID_BIT+1] == '0)
    else $error("option bits visible on the bus");

  lock_reject_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (s_q.phase == ST_RUN) && prog_mode && prog_write && otp_locked |=>
      prog_reject && !s_q.otp_we ##1 !prog_done)
    else $error("write to a programmed option word accepted");

  mask_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    MASK_ROM && (s_q.phase == ST_RUN) && prog_mode && !prog_write &&
      prog_read |=> prog_reject && !prog_done && prog_rdata == '0)
    else $error("mask part returned its option word");

  detector_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(running) && !MASK_ROM |->
      low_voltage_detect_enable == $past(otp_rdata[DETECT_BIT]))
    else $error("detector enable not taken from option word");

  readout_block_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ext_readout_allow |-> !readout_lock && $past(prog_mode))
    else $error("readout allowed while protected");

  readout_open_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(prog_mode) && $past(running) && !readout_lock |->
      ext_readout_allow)
    else $error("readout refused while unprotected");

  osc_select_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(running) && !MASK_ROM |->
      clock_source_select == $past(otp_rdata[CLK_SEL_BIT]))
    else $error("oscillator select not taken from option word");

  pullup_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(running) && !MASK_ROM |->
      nonmaskable_pullup_enable == $past(otp_rdata[PULLUP_BIT]))
    else $error("pull-up enable not taken from option word");

  guard_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(running) && !MASK_ROM |->
      safeguard_enable == $past(otp_rdata[SAFEGUARD_BIT]))
    else $error("safeguard enable not taken from option word");

  bus_answer_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus access not answered in one cycle");

  sw_dog_sticky_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_q.wdog_sw |=> s_q.wdog_sw)
    else $error("software watchdog enable was cleared");

  prog_accept_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    s_q.otp_we ##1 prog_done);

  prog_refuse_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    prog_reject);

  bus_write_c: cover property (
    @(posedge sys_clk) disable iff (rst)
    write && !waitrequest && reg_hit(address, CTRL_OFFSET));
endmodule // option_byte_config

// [verif/prog_tool_model.sv]
// Model of the external programming tool that drives the option word port.
`timescale 1ns/1ps
module prog_tool_model
(
  input  wire logic        sys_clk,
  output logic             prog_mode,
  output logic             prog_write,
  output logic             prog_read,
  output logic [15:0]      prog_wdata,
  input  wire logic [15:0] prog_rdata,
  input  wire logic        prog_done,
  input  wire logic        prog_reject
);
  // The shipped default keeps the part at its lowest consumption.
  localparam logic [15:0] DEFAULT_WORD = 16'h0414;
  localparam logic [15:0] FREE_BITS    = 16'h03cb;
  localparam logic [15:0] FIXED_ONES   = 16'h0414;

  initial
  begin
    prog_mode  = 1'b0;
    prog_write = 1'b0;
    prog_read  = 1'b0;
    prog_wdata = DEFAULT_WORD;
  end

  //////////////////////////////////////////////////////////////////////////
  // One request, held for one edge; the answer is watched over a short
  // window because a request outside programming mode gets none.
  task automatic xfer(input logic mode, input logic wr,
                      input logic [15:0] word, output logic done,
                      output logic rej, output logic [15:0] rdata);
    @(posedge sys_clk);
    prog_mode  <= mode;
    prog_write <= wr;
    prog_read  <= !wr;
    prog_wdata <= (word & FREE_BITS) | FIXED_ONES;
    @(posedge sys_clk);
    prog_write <= 1'b0;
    prog_read  <= 1'b0;
    prog_wdata <= ~prog_wdata;
    done = 1'b0;
    rej  = 1'b0;
    repeat (4)
    begin
      @(negedge sys_clk);
      done |= prog_done;
      rej  |= prog_reject;
    end
    rdata = prog_rdata;
  endtask
endmodule // prog_tool_model

// [verif/test_option_byte_config.sv]
// Self-checking bench for the option word loader.
`timescale 1ns/1ps
module test_option_byte_config import option_cfg_pkg::*;;
  logic              sys_clk, rst, otp_blank, read, write, nmi_level;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, q;
  logic [BE_W-1:0]   byteenable;
  logic              waitrequest, prog_mode, prog_write, prog_read;
  logic              prog_done, prog_reject, dn, rj;
  logic [CFG_W-1:0]  prog_wdata, prog_rdata, rd;
  logic              watchdog_active, stop_grant, config_valid;
  logic              ext_readout_allow, m_reject, m_reject_seen, m_safeguard;
  logic [6:0]        cfg;
  int                fails, checked;

  option_byte_config i_dut (.sys_clk(sys_clk), .rst(rst),
    .otp_blank(otp_blank), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .prog_mode(prog_mode),
    .prog_write(prog_write), .prog_read(prog_read),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_done(prog_done), .prog_reject(prog_reject),
    .nmi_level(nmi_level), .watchdog_active(watchdog_active),
    .stop_grant(stop_grant), .config_valid(config_valid),
    .stop_with_watchdog_enable(cfg[6]), .low_voltage_detect_enable(cfg[5]),
    .readout_lock(cfg[4]), .ext_readout_allow(ext_readout_allow),
    .clock_source_select(cfg[3]), .nonmaskable_pullup_enable(cfg[2]),
    .hardware_watchdog_select(cfg[1]), .safeguard_enable(cfg[0]));

  // A mask part beside the main one sees the same requests.
  option_byte_config #(.MASK_ROM(1'b1), .MASK_CONFIG(16'h0415)) i_mask (
    .sys_clk(sys_clk), .rst(rst), .otp_blank(otp_blank),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(), .waitrequest(),
    .prog_mode(prog_mode), .prog_write(prog_write), .prog_read(prog_read),
    .prog_wdata(prog_wdata), .prog_rdata(), .prog_done(),
    .prog_reject(m_reject), .nmi_level(nmi_level), .watchdog_active(),
    .stop_grant(), .config_valid(), .stop_with_watchdog_enable(),
    .low_voltage_detect_enable(), .readout_lock(), .ext_readout_allow(),
    .clock_source_select(), .nonmaskable_pullup_enable(),
    .hardware_watchdog_select(), .safeguard_enable(m_safeguard));

  prog_tool_model i_tool (.sys_clk(sys_clk), .prog_mode(prog_mode),
    .prog_write(prog_write), .prog_read(prog_read),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_done(prog_done), .prog_reject(prog_reject));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (rst)
      m_reject_seen <= 1'b0;
    else if (m_reject)
      m_reject_seen <= 1'b1;

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    address   <= a;
    write     <= wr;
    read      <= !wr;
    writedata <= d;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // The stop permission settles one cycle after a control write reaches the control register.
  task automatic status(input logic [31:0] e);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check("status", q, e);
    check("dog pin", watchdog_active, e[STAT_WDOG_BIT]);
    check("stop pin", stop_grant, e[STAT_STOP_BIT]);
  endtask

  task automatic check_cfg(input logic [6:0] e);
    check("stop option", cfg[6], e[6]);
    check("detector option", cfg[5], e[5]);
    check("lock option", cfg[4], e[4]);
    check("clock option", cfg[3], e[3]);
    check("pullup option", cfg[2], e[2]);
    check("dog option", cfg[1], e[1]);
    check("guard option", cfg[0], e[0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    fails++;
    conclude;
  end

  initial
  begin
    {rst, otp_blank, read, write, nmi_level} = 5'h18;
    address    = 4'h0;
    writedata  = 32'h0;
    byteenable = 4'h1;
    fails      = 0;
    checked    = 0;
    repeat (5) @(posedge sys_clk);
    rst       <= 1'b0;
    otp_blank <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("valid", config_valid, 32'h1);
    check_cfg(7'h00);
    i_tool.xfer(1'b1, 1'b0, 16'h0000, dn, rj, rd);
    check("blank word", {dn, rd}, {1'b1, SHIPPED_VALUE});
    check("readout open", ext_readout_allow, 32'h1);
    bus(1'b1, CTRL_OFFSET, 32'h2);
    status(32'h6);
    @(posedge sys_clk) nmi_level <= 1'b1;
    bus(1'b1, CTRL_OFFSET, 32'h3);
    status(32'h5);
    bus(1'b1, CTRL_OFFSET, 32'h0);
    status(32'h5);
    i_tool.xfer(1'b1, 1'b1, 16'h07df, dn, rj, rd);
    check("first write", {dn, rj}, 32'h2);
    check_cfg(7'h00);
    i_tool.xfer(1'b1, 1'b1, 16'h0414, dn, rj, rd);
    check("second write", {dn, rj}, 32'h1);
    i_tool.xfer(1'b1, 1'b0, 16'h0000, dn, rj, rd);
    check("word kept", rd, 32'h07df);
    i_tool.xfer(1'b0, 1'b1, 16'h0000, dn, rj, rd);
    check("no prog mode", {dn, rj}, 32'h0);
    check("readout closed", ext_readout_allow, 32'h0);
    // Nothing on the bus may show the programmed word.
    for (int a = 1; a < 16; a++)
    begin
      if (a != 4)
      begin
        bus(1'b0, a[3:0], 32'h0);
        check("unmapped", q, 32'h0);
      end
    end
    bus(1'b1, STATUS_OFFSET, 32'h0);
    status(32'h5);
    check("mask refuses", m_reject_seen, 32'h1);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check_cfg(7'h7f);
    check("mask word", m_safeguard, 32'h1);
    i_tool.xfer(1'b1, 1'b0, 16'h0000, dn, rj, rd);
    check("readout locked", ext_readout_allow, 32'h0);
    @(posedge sys_clk) byteenable <= 4'h0;
    bus(1'b1, CTRL_OFFSET, 32'h2);
    status(32'h5);
    @(posedge sys_clk) nmi_level <= 1'b0;
    byteenable <= 4'h1;
    bus(1'b1, CTRL_OFFSET, 32'h2);
    status(32'h5);
    @(posedge sys_clk) nmi_level <= 1'b1;
    status(32'h7);
    conclude;
  end
endmodule // test_option_byte_config
